// ---- pin_if.sv ----
// Synchronised pin levels and edges between pin stage and front end
`timescale 1ns/1ps
interface pin_if;
	logic sclk;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_rise;
	logic cs_fall;
	logic cs_n;
	logic mosi;
	logic hold_n;
	logic wp_n;
	modport src (output sclk, sclk_rise, sclk_fall, cs_rise, cs_fall, cs_n,
		mosi, hold_n, wp_n);
	modport dst (input sclk, sclk_rise, sclk_fall, cs_rise, cs_fall, cs_n,
		mosi, hold_n, wp_n);
endinterface

// ---- pin_sync.sv ----
// Two-stage pin synchroniser with clock and select edge detection
`timescale 1ns/1ps
`include "spi_fe_regs.svh"
module pin_sync
(
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic sclk_pin,
	input  wire logic cs_n_pin,
	input  wire logic mosi_pin,
	input  wire logic hold_n_pin,
	input  wire logic wp_n_pin,
	pin_if.src        pins
);
	// Bit order {wp_n, hold_n, mosi, cs_n, sclk}; cs_n resets low so a
	// select already low at power-up never looks like a falling edge
	logic [4:0] meta;
	logic [4:0] stab;
	logic [1:0] last;
	logic [4:0] next_meta;
	logic [4:0] next_stab;
	logic [1:0] next_last;

	always_comb
	begin
		next_meta = {wp_n_pin, hold_n_pin, mosi_pin, cs_n_pin, sclk_pin};
		next_stab = meta;
		next_last = stab[1:0];
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta <= `FE_SYNC_RST;
			stab <= `FE_SYNC_RST;
			last <= 2'(`FE_SYNC_RST);
		end
		else
		begin
			meta <= next_meta;
			stab <= next_stab;
			last <= next_last;
		end
	end

	assign pins.sclk      = stab[0];
	assign pins.sclk_rise = stab[0] & ~last[0];
	assign pins.sclk_fall = ~stab[0] & last[0];
	assign pins.cs_n      = stab[1];
	assign pins.cs_fall   = ~stab[1] & last[1];
	assign pins.cs_rise   = stab[1] & ~last[1];
	assign pins.mosi      = stab[2];
	assign pins.hold_n    = stab[3];
	assign pins.wp_n      = stab[4];
endmodule

// ---- spi_eeprom_serial_front_end_tb.sv ----
// Self-checking bench for the serial EEPROM front end
`timescale 1ns/1ps
module spi_eeprom_serial_front_end_tb;
	logic ref_clk;
	logic rst_n;
	logic wcycle_busy;
	logic bp_load;
	logic bp_hi_new;
	logic bp_lo_new;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic hold_n;
	logic wp_n;
	logic so_out;
	logic so_oe_n;
	logic standby;
	logic protect_size_hi;
	logic protect_size_lo;
	logic [7:0] rxb;
	logic [1:0] bp;
	int errors;
	int n_tests;
	int seed;
	int mem [0:2047];
	int tbl [0:5] = '{0, 1023, 1024, 1535, 1536, 2047};

	spi_fe #(.DEPTH(2048)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.sclk_pin(sclk), .cs_n_pin(cs_n), .mosi_pin(mosi),
		.hold_n_pin(hold_n), .wp_n_pin(wp_n), .wcycle_busy(wcycle_busy),
		.bp_load(bp_load), .bp_hi_new(bp_hi_new), .bp_lo_new(bp_lo_new),
		.so_out(so_out), .so_oe_n(so_oe_n), .standby(standby),
		.protect_size_hi(protect_size_hi),
		.protect_size_lo(protect_size_lo));
	spi_master_model u_m (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe_n(so_oe_n));

	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("Checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	function automatic bit prot(input int a);
		case (bp)
			2'h1: return a >= 1536;
			2'h2: return a >= 1024;
			2'h3: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction
	task automatic xb(input logic [7:0] t);
		u_m.byte_io(t, rxb, -1);
	endtask
	task automatic open_frame(input logic [7:0] op, input int a);
		u_m.start(1'($random(seed)));
		check("standby sel", {7'h0, standby}, 8'h00);
		xb(op);
		xb(8'(a >> 8));
		xb(8'(a));
	endtask
	task automatic close_frame();
		u_m.stop();
		check("oe off", {7'h0, so_oe_n}, 8'h01);
		check("standby", {7'h0, standby}, 8'h01);
	endtask
	task automatic wr(input int a, input int n);
		logic [7:0] d;
		open_frame(8'h02, a);
		for (int k = 0; k < n; k++)
		begin
			d = 8'($random(seed));
			xb(d);
			if (!prot(a))
				mem[a] = d;
			a = (a + 1) % 2048;
		end
		close_frame();
	endtask
	task automatic rd(input int a, input int n, input int hold_at);
		open_frame(8'h03, a);
		for (int k = 0; k < n; k++)
		begin
			u_m.byte_io(8'h00, rxb, (k == 0) ? hold_at : -1);
			if (mem[a] >= 0)
				check("read", rxb, 8'(mem[a]));
			a = (a + 1) % 2048;
		end
		close_frame();
	endtask
	task automatic set_bp(input logic [1:0] v);
		@(posedge ref_clk);
		bp_hi_new <= v[1];
		bp_lo_new <= v[0];
		bp_load <= 1'b1;
		@(posedge ref_clk);
		bp_load <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		if (wp_n)
			bp = v;
		check("bp", {6'h0, protect_size_hi, protect_size_lo}, {6'h0, bp});
	endtask

	initial
	begin
		int a;
		seed = 32'h9c3009d9;
		foreach (mem[i]) mem[i] = -1;
		bp = 2'h0;
		rst_n = 1'b0;
		wcycle_busy = 1'b0;
		bp_load = 1'b0;
		bp_hi_new = 1'b0;
		bp_lo_new = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		check("rst oe", {7'h0, so_oe_n}, 8'h01);
		check("rst bp", {6'h0, protect_size_hi, protect_size_lo}, 8'h00);
		rst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		// Pin changes stay off the clock edges that sample them
		#10;
		// Select already low at power-up: a read must not answer
		xb(8'h03);
		xb(8'h00);
		xb(8'h10);
		xb(8'h00);
		check("no sel", {7'h0, u_m.drove}, 8'h00);
		u_m.stop();
		$display("test power-up select done");
		for (int k = 0; k < 6; k++)
		begin
			a = $unsigned($random(seed)) % 2048;
			wr(a, 1 + k % 3);
			rd(a, 1 + k % 3, -1);
		end
		wr(2046, 4);
		rd(2046, 4, -1);
		$display("test write read done");
		open_frame(8'hA5, 0);
		xb(8'h00);
		check("bad op", {7'h0, u_m.drove}, 8'h00);
		close_frame();
		rd(2046, 2, 3);
		check("hold oe", {7'h0, u_m.hold_oe}, 8'h01);
		u_m.start(1'b0);
		xb(8'h03);
		u_m.abort_hold();
		rd(2046, 2, -1);
		$display("test hold done");
		for (int v = 0; v < 4; v++)
		begin
			set_bp(2'h0);
			foreach (tbl[i]) wr(tbl[i], 1);
			set_bp(2'(v));
			foreach (tbl[i]) wr(tbl[i], 1);
			foreach (tbl[i]) rd(tbl[i], 1, -1);
		end
		u_m.set_wp(1'b0);
		set_bp(2'h0);
		wr(0, 1);
		rd(0, 1, -1);
		u_m.set_wp(1'b1);
		$display("test protect done");
		@(posedge ref_clk);
		wcycle_busy <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		check("busy", {7'h0, standby}, 8'h00);
		wcycle_busy <= 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
		check("idle", {7'h0, standby}, 8'h01);
		$display("test standby done");
		report_and_stop();
	end

	initial
	begin
		repeat (60000) @(posedge ref_clk);
		errors++;
		report_and_stop();
	end
endmodule

// ---- spi_fe.sv ----
// Serial EEPROM front end: select, hold, shifting, array and protect bits
`timescale 1ns/1ps
`include "spi_fe_regs.svh"
module spi_fe
#(
	parameter int DEPTH = `FE_DEPTH_LARGE
)
(
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic sclk_pin,
	input  wire logic cs_n_pin,
	input  wire logic mosi_pin,
	input  wire logic hold_n_pin,
	input  wire logic wp_n_pin,
	input  wire logic wcycle_busy,
	input  wire logic bp_load,
	input  wire logic bp_hi_new,
	input  wire logic bp_lo_new,
	output logic      so_out,
	output logic      so_oe_n,
	output logic      standby,
	output logic      protect_size_hi,
	output logic      protect_size_lo
);
	localparam int AW = $clog2(DEPTH);

	pin_if p ();

	pin_sync u_sync
	(
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.sclk_pin   (sclk_pin),
		.cs_n_pin   (cs_n_pin),
		.mosi_pin   (mosi_pin),
		.hold_n_pin (hold_n_pin),
		.wp_n_pin   (wp_n_pin),
		.pins       (p)
	);

	// Protected range from the two setting bits: none, top quarter,
	// top half, everything
	function automatic logic is_protected(input logic [AW-1:0] a,
		input logic hi, input logic lo);
		logic [1:0] top;
		top = a[AW-1:AW-2];
		case ({hi, lo})
			2'h1:    is_protected = (top == 2'h3);
			2'h2:    is_protected = top[1];
			2'h3:    is_protected = 1'b1;
			default: is_protected = 1'b0;
		endcase
	endfunction

	logic [7:0]            mem [DEPTH];
	spi_fe_pkg::fe_state_t state;
	spi_fe_pkg::fe_state_t next_state;
	logic                  selected;
	logic                  next_selected;
	logic                  hold_active;
	logic                  next_hold_active;
	logic                  driving;
	logic                  next_driving;
	logic                  is_read;
	logic                  next_is_read;
	logic [2:0]            bit_cnt;
	logic [2:0]            next_bit_cnt;
	logic [2:0]            out_cnt;
	logic [2:0]            next_out_cnt;
	logic [1:0]            addr_bytes;
	logic [1:0]            next_addr_bytes;
	logic [7:0]            in_sr;
	logic [7:0]            next_in_sr;
	logic [7:0]            out_sr;
	logic [7:0]            next_out_sr;
	logic [15:0]           addr;
	logic [15:0]           next_addr;
	logic                  next_so_out;
	logic                  next_so_oe_n;
	logic                  next_standby;
	logic                  next_bp_hi;
	logic                  next_bp_lo;
	logic                  mem_we;
	logic [AW-1:0]         mem_idx;
	logic [7:0]            mem_rd;
	logic [7:0]            in_word;

	assign mem_idx = addr[AW-1:0];
	assign mem_rd  = mem[mem_idx];

	always_comb
	begin
		next_state       = state;
		next_selected    = selected;
		next_hold_active = hold_active;
		next_driving     = driving;
		next_is_read     = is_read;
		next_bit_cnt     = bit_cnt;
		next_out_cnt     = out_cnt;
		next_addr_bytes  = addr_bytes;
		next_in_sr       = in_sr;
		next_out_sr      = out_sr;
		next_addr        = addr;
		next_so_out      = so_out;
		mem_we           = 1'b0;
		in_word          = {in_sr[6:0], p.mosi};
		if (p.cs_rise)
		begin
			// Deselect drops everything, hold included
			next_state       = spi_fe_pkg::ST_OFF;
			next_selected    = 1'b0;
			next_hold_active = 1'b0;
			next_driving     = 1'b0;
		end
		else if (p.cs_fall)
		begin
			// Only an edge selects, so a low level at power-up does not
			next_state      = spi_fe_pkg::ST_CMD;
			next_selected   = 1'b1;
			next_bit_cnt    = 3'h0;
			next_out_cnt    = 3'h0;
			next_addr_bytes = 2'h0;
			next_driving    = 1'b0;
		end
		else if (selected)
		begin
			// Hold changes only while the clock is low
			if (!p.sclk)
				next_hold_active = !p.hold_n;
			if (!hold_active)
			begin
				if (p.sclk_rise)
				begin
					next_in_sr   = in_word;
					next_bit_cnt = bit_cnt + 3'h1;
					if (bit_cnt == `FE_BYTE_LAST)
					begin
						case (state)
							spi_fe_pkg::ST_CMD:
							begin
								next_is_read = (in_word == `FE_CMD_READ);
								if (in_word == `FE_CMD_READ ||
									in_word == `FE_CMD_WRITE)
									next_state = spi_fe_pkg::ST_ADDR;
								else
									next_state = spi_fe_pkg::ST_SKIP;
							end
							spi_fe_pkg::ST_ADDR:
							begin
								next_addr       = {addr[7:0], in_word};
								next_addr_bytes = addr_bytes + 2'h1;
								if (next_addr_bytes == `FE_ADDR_BYTES)
									next_state = is_read ?
										spi_fe_pkg::ST_RDATA :
										spi_fe_pkg::ST_WDATA;
							end
							spi_fe_pkg::ST_WDATA:
							begin
								// Protected bytes are dropped silently
								mem_we    = !is_protected(mem_idx,
									protect_size_hi, protect_size_lo);
								next_addr = addr + 16'h1;
							end
							default:
							begin
								next_state = state;
							end
						endcase
					end
				end
				else if (p.sclk_fall && state == spi_fe_pkg::ST_RDATA)
				begin
					next_driving = 1'b1;
					next_out_cnt = out_cnt + 3'h1;
					if (out_cnt == 3'h0)
					begin
						// Fetch a byte and send its top bit first
						next_so_out = mem_rd[7];
						next_out_sr = {mem_rd[6:0], 1'b0};
						next_addr   = addr + 16'h1;
					end
					else
					begin
						next_so_out = out_sr[7];
						next_out_sr = {out_sr[6:0], 1'b0};
					end
				end
			end
		end
		next_so_oe_n = !(next_selected && next_driving && !next_hold_active);
		next_standby = !next_selected && !wcycle_busy;
		// Write protect low freezes the protect setting
		next_bp_hi = (bp_load && p.wp_n) ? bp_hi_new : protect_size_hi;
		next_bp_lo = (bp_load && p.wp_n) ? bp_lo_new : protect_size_lo;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state           <= spi_fe_pkg::ST_OFF;
			selected        <= 1'b0;
			hold_active     <= 1'b0;
			driving         <= 1'b0;
			is_read         <= 1'b0;
			bit_cnt         <= 3'h0;
			out_cnt         <= 3'h0;
			addr_bytes      <= 2'h0;
			in_sr           <= 8'h00;
			out_sr          <= 8'h00;
			addr            <= 16'h0000;
			so_out          <= 1'b0;
			so_oe_n         <= 1'b1;
			standby         <= 1'b1;
			protect_size_hi <= 1'(`FE_PROT_RST >> 1);
			protect_size_lo <= 1'(`FE_PROT_RST);
		end
		else
		begin
			state           <= next_state;
			selected        <= next_selected;
			hold_active     <= next_hold_active;
			driving         <= next_driving;
			is_read         <= next_is_read;
			bit_cnt         <= next_bit_cnt;
			out_cnt         <= next_out_cnt;
			addr_bytes      <= next_addr_bytes;
			in_sr           <= next_in_sr;
			out_sr          <= next_out_sr;
			addr            <= next_addr;
			so_out          <= next_so_out;
			so_oe_n         <= next_so_oe_n;
			standby         <= next_standby;
			protect_size_hi <= next_bp_hi;
			protect_size_lo <= next_bp_lo;
		end
	end

	// Array keeps no reset: its content is non-volatile by nature
	always_ff @(posedge ref_clk)
	begin
		if (mem_we)
			mem[mem_idx] <= in_word;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_cs_high_float;
		p.cs_rise |=> so_oe_n ##1 so_oe_n;
	endproperty
	a_cs_high_float: assert property (p_cs_high_float)
		else $error("output driven after deselect");

	property p_hold_float;
		hold_active |-> so_oe_n;
	endproperty
	a_hold_float: assert property (p_hold_float)
		else $error("output driven during hold");

	property p_hold_keeps_bit;
		hold_active && !p.cs_rise && !p.cs_fall |=>
			bit_cnt == $past(bit_cnt) && state == $past(state);
	endproperty
	a_hold_keeps_bit: assert property (p_hold_keeps_bit)
		else $error("bit position moved during hold");

	property p_sample_rise;
		selected && !hold_active && p.sclk_rise && !p.cs_rise &&
			!p.cs_fall |=> in_sr[0] == $past(p.mosi) &&
			bit_cnt == $past(bit_cnt) + 3'h1;
	endproperty
	a_sample_rise: assert property (p_sample_rise)
		else $error("input bit not taken on rising edge");

	property p_no_count_idle;
		!p.sclk_rise && !p.cs_fall |=> $stable(bit_cnt);
	endproperty
	a_no_count_idle: assert property (p_no_count_idle)
		else $error("bit count moved without rising edge");

	property p_out_on_fall;
		!$stable(so_out) |-> $past(p.sclk_fall);
	endproperty
	a_out_on_fall: assert property (p_out_on_fall)
		else $error("output changed without falling edge");

	property p_first_fall_drives;
		selected && state == spi_fe_pkg::ST_RDATA && !driving &&
			!hold_active && p.sclk_fall && !p.cs_rise && !p.cs_fall
			|=> !so_oe_n && driving;
	endproperty
	a_first_fall_drives: assert property (p_first_fall_drives)
		else $error("read output not started on first falling edge");

	property p_msb_out;
		selected && state == spi_fe_pkg::ST_RDATA && !hold_active &&
			p.sclk_fall && out_cnt == 3'h0 && !p.cs_rise && !p.cs_fall
			|=> so_out == $past(mem_rd[7]) ##1 so_out == $past(so_out);
	endproperty
	a_msb_out: assert property (p_msb_out)
		else $error("byte not sent top bit first");

	property p_fall_restarts;
		p.cs_fall |=> bit_cnt == 3'h0 && selected &&
			state == spi_fe_pkg::ST_CMD;
	endproperty
	a_fall_restarts: assert property (p_fall_restarts)
		else $error("select fall did not restart the transfer");

	property p_edge_selects;
		!selected && !p.cs_fall |=> !selected;
	endproperty
	a_edge_selects: assert property (p_edge_selects)
		else $error("selected without a select falling edge");

	property p_standby;
		p.cs_rise && !wcycle_busy |=> standby;
	endproperty
	a_standby: assert property (p_standby)
		else $error("no standby after deselect");

	property p_protect_frozen;
		!p.wp_n |=> $stable(protect_size_hi) && $stable(protect_size_lo);
	endproperty
	a_protect_frozen: assert property (p_protect_frozen)
		else $error("protect setting changed while frozen");
endmodule

// ---- spi_fe_pkg.sv ----
// Types shared by the serial EEPROM front end
package spi_fe_pkg;
	typedef enum logic [5:0]
	{
		ST_OFF   = 6'h01,
		ST_CMD   = 6'h02,
		ST_ADDR  = 6'h04,
		ST_WDATA = 6'h08,
		ST_RDATA = 6'h10,
		ST_SKIP  = 6'h20
	} fe_state_t;
endpackage

// ---- spi_fe_regs.svh ----
// Constants for the serial EEPROM front end
// Summary of operation
// - Memory array holds 2048 bytes, or 1024 bytes in the smaller variant.
// - Serial output changes on falling edges of the serial clock.
// - Serial input is captured on rising edges of the serial clock.
// - While select is high the device is deselected and output tri-stated.
// - Standby if deselected and no write cycle runs; select low is active.
// - After power-up nothing is accepted until a falling edge of select.
// - During hold the output floats and clock and input are ignored.
// - Hold pauses a transfer without deselecting; it resumes at the same bit.
// - Hold starts and ends on hold edges while the serial clock is low.
// - Select rising during hold resets the interface and drops instruction.
// - Write protect low freezes the two block-protect setting bits.
// - Instructions, addresses and data arrive most significant bit first.
// - First input bit is taken on the first rising edge after select falls.
// - Output bytes leave most significant bit first.
// - Read output starts on first falling edge after the last address bit.
// - Clock modes 0 and 3 both work: sample on rise, output on fall.
`ifndef SPI_FE_REGS_SVH
`define SPI_FE_REGS_SVH
`define FE_DEPTH_LARGE 2048
`define FE_DEPTH_SMALL 1024
`define FE_CMD_READ    8'h03
`define FE_CMD_WRITE   8'h02
`define FE_ADDR_BYTES  2'h2
`define FE_BYTE_LAST   3'h7
`define FE_SYNC_RST    5'h18
`define FE_PROT_RST    2'h0
`endif

// ---- spi_master_model.sv ----
// Bus master model driving the serial pins of the front end
`timescale 1ns/1ps
module spi_master_model
(
	output logic      sclk,
	output logic      cs_n,
	output logic      mosi,
	output logic      hold_n,
	output logic      wp_n,
	input  wire logic so_out,
	input  wire logic so_oe_n
);
	logic mode3;
	logic drove;
	logic hold_oe;
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b0;
		mosi = 1'b0;
		hold_n = 1'b1;
		wp_n = 1'b1;
		mode3 = 1'b0;
		drove = 1'b0;
		hold_oe = 1'b0;
	end
	// Clock parks at the mode level; select rises before it falls
	task automatic start(input logic m3);
		mode3 = m3;
		sclk = m3;
		cs_n = 1'b1;
		#200;
		cs_n = 1'b0;
		drove = 1'b0;
		#200;
	endtask
	// Data set while clock low; output read late in the high phase
	task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx,
		input int hold_at);
		for (int i = 7; i >= 0; i--)
		begin
			sclk = 1'b0;
			mosi = tx[i];
			#100;
			if (i == hold_at)
			begin
				// Hold edges only while clock low, select kept low
				hold_n = 1'b0;
				#200;
				sclk = 1'b1;
				mosi = ~mosi;
				#100;
				hold_oe = so_oe_n;
				sclk = 1'b0;
				#100;
				hold_n = 1'b1;
				mosi = tx[i];
				#200;
			end
			sclk = 1'b1;
			#100;
			// A released line carries no data, so it reads inverted
			rx[i] = so_oe_n ? ~so_out : so_out;
			if (so_oe_n === 1'b0)
				drove = 1'b1;
		end
	endtask
	// Only this target is ever selected, so the output line is ours
	task automatic stop();
		sclk = mode3;
		#100;
		cs_n = 1'b1;
		mosi = ~mosi;
		#200;
	endtask
	task automatic abort_hold();
		sclk = 1'b0;
		#100;
		hold_n = 1'b0;
		#200;
		cs_n = 1'b1;
		#200;
		hold_n = 1'b1;
		mosi = ~mosi;
		#200;
	endtask
	// Write protect is changed only between frames
	task automatic set_wp(input logic v);
		wp_n = v;
		#200;
	endtask
endmodule
